// ---- common/hscc_pkg.sv ----
// holds the constants, register map and enumerations of the fast count/compare block
// assumes a single 200 MHz clock domain and a word-addressed avalon-mm slave
package hscc_pkg;
   // ------------------------------------------------------------
   // widths and counts
   // ------------------------------------------------------------
   localparam int ADDR_W    = 6;
   localparam int DATA_W    = 32;
   localparam int NUM_SLOTS = 8;
   localparam int MAX_ACT   = 6;
   localparam int NUM_POS   = 6;
   localparam int OUT_W     = 16;
   localparam int IRQ_W     = 12;
   localparam int CNT_IRQS  = 6;

   // ------------------------------------------------------------
   // register word addresses
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] A_CTRL     = 6'h00;
   localparam logic [ADDR_W-1:0] A_COUNT    = 6'h01;
   localparam logic [ADDR_W-1:0] A_PRESET   = 6'h02;
   localparam logic [ADDR_W-1:0] A_STATE    = 6'h03;
   localparam logic [ADDR_W-1:0] A_OUTBITS  = 6'h04;
   localparam logic [ADDR_W-1:0] A_IRQ_STS  = 6'h05;
   localparam logic [ADDR_W-1:0] A_IRQ_MASK = 6'h06;
   localparam logic [ADDR_W-1:0] A_SCAN     = 6'h07;
   localparam logic [ADDR_W-1:0] A_SLOT_CFG = 6'h08;
   localparam logic [ADDR_W-1:0] A_SLOT_VAL = 6'h10;
   localparam logic [ADDR_W-1:0] A_POS      = 6'h18;
   localparam logic [ADDR_W-1:0] A_POS_CMP  = 6'h1E;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN    = 0;
   localparam int CTRL_QUAD  = 1;
   localparam int CTRL_DOWN  = 2;
   localparam int CTRL_START = 3;
   localparam int CFG_EN     = 0;
   localparam int CFG_FN_LO  = 1;
   localparam int CFG_TGTCNT = 3;
   localparam int CFG_TGT_LO = 4;
   localparam int POS_IRQ_LO = 6;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [3:0]        RST_CTRL = 4'h0;
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
   localparam logic [OUT_W-1:0]  RST_OUT  = 16'h0000;
   localparam logic [IRQ_W-1:0]  RST_IRQ  = 12'h000;
   localparam logic [7:0]        RST_CFG  = 8'h00;

   typedef enum logic [1:0] {HSCC_FN_SET, HSCC_FN_CLR, HSCC_FN_IRQ, HSCC_FN_NONE} hscc_fn_e;
   typedef enum logic [1:0] {HSCC_BUS_IDLE, HSCC_BUS_ACK} hscc_bus_e;
endpackage

// ---- core/hscc_top.sv ----
// fast pulse counter with six-at-once compare actions and position compare interrupts
// assumes pulse, start and clear pins are asynchronous; position steps come from same-clock logic
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module hscc_top
   import hscc_pkg::*;
(
   input  wire logic                        ref_clk_i,
   input  wire logic                        srst_i,
   input  wire logic [hscc_pkg::ADDR_W-1:0] avs_address_i,
   input  wire logic                        avs_read_i,
   input  wire logic                        avs_write_i,
   input  wire logic [hscc_pkg::DATA_W-1:0] avs_writedata_i,
   output logic      [hscc_pkg::DATA_W-1:0] avs_readdata_o,
   output logic                             avs_waitrequest_o,
   input  wire logic                        pulse_a_i,
   input  wire logic                        pulse_b_i,
   input  wire logic                        ext_start_i,
   input  wire logic                        ext_clear_i,
   input  wire logic [hscc_pkg::NUM_POS-1:0] pos_step_i,
   input  wire logic [hscc_pkg::NUM_POS-1:0] pos_dir_down_i,
   output logic      [hscc_pkg::OUT_W-1:0]  target_bits_o,
   output logic                             scan_contact_o,
   output logic                             irq_o
);
   import hscc_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // slots beyond the sixth enabled one are ignored, in slot order
   function automatic logic [NUM_SLOTS-1:0] first_active(input logic [NUM_SLOTS-1:0] en);
      logic [NUM_SLOTS-1:0] act;
      int                   n;
      act = '0;
      n   = 0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         if (en[i] && n < MAX_ACT) begin
            act[i] = 1'b1;
         end
         if (en[i]) begin
            n++;
         end
      end
      return act;
   endfunction

   function automatic logic signed [DATA_W-1:0] step_val(input logic signed [DATA_W-1:0] v,
                                                         input logic down);
      return down ? v - 32'sd1 : v + 32'sd1;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [3:0]                   ctrl_ff;
   logic signed [DATA_W-1:0]     count_ff;
   logic signed [DATA_W-1:0]     preset_ff;
   logic                         contact_ff;
   logic                         qdir_ff;
   logic                         scan_out_ff;
   logic [OUT_W-1:0]             out_bits_ff;
   logic [IRQ_W-1:0]             irq_sts_ff;
   logic [IRQ_W-1:0]             irq_mask_ff;
   logic                         irq_ff;
   logic [7:0]                   cfg_ff   [NUM_SLOTS];
   logic signed [DATA_W-1:0]     val_ff   [NUM_SLOTS];
   logic signed [DATA_W-1:0]     pos_ff   [NUM_POS];
   logic signed [DATA_W-1:0]     pcmp_ff  [NUM_POS];
   logic [3:0]                   sync1_ff;
   logic [3:0]                   sync2_ff;
   logic                         a_prev_ff;
   hscc_bus_e                    bus_ff;
   logic [DATA_W-1:0]            rdata_ff;
   logic                         wait_ff;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // first stage feeds only the second; edge detect looks at stage two
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sync1_ff  <= 4'h0;
         sync2_ff  <= 4'h0;
         a_prev_ff <= 1'b0;
      end else begin
         sync1_ff  <= {ext_clear_i, ext_start_i, pulse_b_i, pulse_a_i};
         sync2_ff  <= sync1_ff;
         a_prev_ff <= sync2_ff[0];
      end
   end

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic                  bus_take;
   logic                  wr_en;
   logic [NUM_SLOTS-1:0]  wr_cfg;
   logic [NUM_SLOTS-1:0]  wr_val;
   logic [NUM_POS-1:0]    wr_pos;
   logic [NUM_POS-1:0]    wr_pcmp;
   logic                  wr_count;

   // a request is acted on in the one cycle waitrequest is low
   assign bus_take = (avs_read_i || avs_write_i) && (bus_ff == HSCC_BUS_ACK);
   assign wr_en    = bus_take && avs_write_i;
   assign wr_count = wr_en && (avs_address_i == A_COUNT);

   always_comb begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
         wr_cfg[i] = wr_en && (avs_address_i == A_SLOT_CFG + ADDR_W'(i));
         wr_val[i] = wr_en && (avs_address_i == A_SLOT_VAL + ADDR_W'(i));
      end
      for (int k = 0; k < NUM_POS; k++) begin
         wr_pos[k]  = wr_en && (avs_address_i == A_POS + ADDR_W'(k));
         wr_pcmp[k] = wr_en && (avs_address_i == A_POS_CMP + ADDR_W'(k));
      end
   end

   // ------------------------------------------------------------
   // counting
   // ------------------------------------------------------------
   logic                     count_ok;
   logic                     a_rise;
   logic                     step;
   logic                     dir_down;
   logic                     clr_in;
   logic signed [DATA_W-1:0] nxt_count;

   assign count_ok  = ctrl_ff[CTRL_EN] && (!ctrl_ff[CTRL_START] || sync2_ff[2]);
   assign a_rise    = sync2_ff[0] && !a_prev_ff;
   assign clr_in    = count_ok && sync2_ff[3];
   // software load wins the cycle, so a load never doubles as a pulse step
   assign step      = count_ok && a_rise && !clr_in && !wr_count;
   // x1 quadrature decode: b low at a's rise means a leads
   assign dir_down  = ctrl_ff[CTRL_QUAD] ? sync2_ff[1] : ctrl_ff[CTRL_DOWN];
   assign nxt_count = step_val(count_ff, dir_down);

   // ------------------------------------------------------------
   // compare slots
   // ------------------------------------------------------------
   logic [NUM_SLOTS-1:0] slot_en;
   logic [NUM_SLOTS-1:0] active;
   logic [NUM_SLOTS-1:0] hit;
   logic [OUT_W-1:0]     set_mask;
   logic [OUT_W-1:0]     clr_mask;
   logic [IRQ_W-1:0]     evt_set;
   logic                 cnt_zero;
   logic [NUM_POS-1:0]   pos_hit;

   // value compared is the new count, so holding at the value cannot re-fire
   always_comb begin
      set_mask = '0;
      clr_mask = '0;
      evt_set  = '0;
      cnt_zero = 1'b0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         slot_en[i] = cfg_ff[i][CFG_EN];
      end
      active = first_active(slot_en);
      for (int i = 0; i < NUM_SLOTS; i++) begin
         hit[i] = step && active[i] && (nxt_count == val_ff[i]);
         if (hit[i]) begin
            case (hscc_fn_e'(cfg_ff[i][CFG_FN_LO +: 2]))
               HSCC_FN_SET: set_mask[cfg_ff[i][CFG_TGT_LO +: 4]] = 1'b1;
               HSCC_FN_CLR: begin
                  if (cfg_ff[i][CFG_TGTCNT]) begin
                     cnt_zero = 1'b1;
                  end else begin
                     clr_mask[cfg_ff[i][CFG_TGT_LO +: 4]] = 1'b1;
                  end
               end
               HSCC_FN_IRQ: begin
                  // numbers outside zero..five are dropped
                  if (cfg_ff[i][CFG_TGT_LO +: 4] < 4'(CNT_IRQS)) begin
                     evt_set[cfg_ff[i][CFG_TGT_LO +: 3]] = 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end
      for (int k = 0; k < NUM_POS; k++) begin
         pos_hit[k] = pos_step_i[k] && !wr_pos[k] &&
                      (step_val(pos_ff[k], pos_dir_down_i[k]) == pcmp_ff[k]);
         evt_set[POS_IRQ_LO + k] = pos_hit[k];
      end
   end

   // ------------------------------------------------------------
   // counter, contact and direction flag
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         count_ff   <= RST_WORD;
         contact_ff <= 1'b0;
         qdir_ff    <= 1'b0;
      end else begin
         if (wr_count) begin
            count_ff <= avs_writedata_i;
         end else if (clr_in || cnt_zero) begin
            count_ff <= RST_WORD;
         end else if (step) begin
            count_ff <= nxt_count;
         end
         if (clr_in) begin
            contact_ff <= 1'b0;
         end else if (step && nxt_count == preset_ff) begin
            contact_ff <= !dir_down;
         end
         if (step && ctrl_ff[CTRL_QUAD]) begin
            qdir_ff <= !sync2_ff[1];
         end
      end
   end

   // contact-driven output follows the scan, not the pulse
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         scan_out_ff <= 1'b0;
      end else if (wr_en && avs_address_i == A_SCAN) begin
         scan_out_ff <= contact_ff;
      end
   end

   // ------------------------------------------------------------
   // target bits: hardware action beats a software write, set beats clear
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         out_bits_ff <= RST_OUT;
      end else if (wr_en && avs_address_i == A_OUTBITS) begin
         out_bits_ff <= (avs_writedata_i[OUT_W-1:0] & ~clr_mask) | set_mask;
      end else begin
         out_bits_ff <= (out_bits_ff & ~clr_mask) | set_mask;
      end
   end

   // ------------------------------------------------------------
   // interrupts: sticky, write one to clear, new event wins
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         irq_sts_ff  <= RST_IRQ;
         irq_mask_ff <= RST_IRQ;
         irq_ff      <= 1'b0;
      end else begin
         if (wr_en && avs_address_i == A_IRQ_STS) begin
            irq_sts_ff <= (irq_sts_ff & ~avs_writedata_i[IRQ_W-1:0]) | evt_set;
         end else begin
            irq_sts_ff <= irq_sts_ff | evt_set;
         end
         if (wr_en && avs_address_i == A_IRQ_MASK) begin
            irq_mask_ff <= avs_writedata_i[IRQ_W-1:0];
         end
         irq_ff <= |(irq_sts_ff & irq_mask_ff);
      end
   end

   // ------------------------------------------------------------
   // configuration, compare values, positions
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ctrl_ff   <= RST_CTRL;
         preset_ff <= RST_WORD;
         for (int i = 0; i < NUM_SLOTS; i++) begin
            cfg_ff[i] <= RST_CFG;
            val_ff[i] <= RST_WORD;
         end
      end else begin
         if (wr_en && avs_address_i == A_CTRL) begin
            ctrl_ff <= avs_writedata_i[3:0];
         end
         if (wr_en && avs_address_i == A_PRESET) begin
            preset_ff <= avs_writedata_i;
         end
         for (int i = 0; i < NUM_SLOTS; i++) begin
            if (wr_cfg[i]) begin
               cfg_ff[i] <= avs_writedata_i[7:0];
            end
            if (wr_val[i]) begin
               val_ff[i] <= avs_writedata_i;
            end
         end
      end
   end

   // a software write to a position simply loads it; only steps compare
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         for (int k = 0; k < NUM_POS; k++) begin
            pos_ff[k]  <= RST_WORD;
            pcmp_ff[k] <= RST_WORD;
         end
      end else begin
         for (int k = 0; k < NUM_POS; k++) begin
            if (wr_pos[k]) begin
               pos_ff[k] <= avs_writedata_i;
            end else if (pos_step_i[k]) begin
               pos_ff[k] <= step_val(pos_ff[k], pos_dir_down_i[k]);
            end
            if (wr_pcmp[k]) begin
               pcmp_ff[k] <= avs_writedata_i;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // avalon slave: fixed one wait state, unmapped reads give zero
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux;

   always_comb begin
      rd_mux = RST_WORD;
      if (avs_address_i >= A_POS_CMP && avs_address_i < A_POS_CMP + ADDR_W'(NUM_POS)) begin
         rd_mux = pcmp_ff[3'(avs_address_i - A_POS_CMP)];
      end else if (avs_address_i >= A_POS && avs_address_i < A_POS_CMP) begin
         rd_mux = pos_ff[3'(avs_address_i - A_POS)];
      end else if (avs_address_i >= A_SLOT_VAL && avs_address_i < A_POS) begin
         rd_mux = val_ff[3'(avs_address_i - A_SLOT_VAL)];
      end else if (avs_address_i >= A_SLOT_CFG && avs_address_i < A_SLOT_VAL) begin
         rd_mux = {24'h00_0000, cfg_ff[3'(avs_address_i - A_SLOT_CFG)]};
      end else begin
         case (avs_address_i)
            A_CTRL:     rd_mux = {28'h000_0000, ctrl_ff};
            A_COUNT:    rd_mux = count_ff;
            A_PRESET:   rd_mux = preset_ff;
            A_STATE:    rd_mux = {29'h0000_0000, scan_out_ff, qdir_ff, contact_ff};
            A_OUTBITS:  rd_mux = {16'h0000, out_bits_ff};
            A_IRQ_STS:  rd_mux = {20'h0_0000, irq_sts_ff};
            A_IRQ_MASK: rd_mux = {20'h0_0000, irq_mask_ff};
            default:    rd_mux = RST_WORD;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         bus_ff   <= HSCC_BUS_IDLE;
         rdata_ff <= RST_WORD;
         wait_ff  <= 1'b1;
      end else begin
         wait_ff <= 1'b1;                     // only a request seen in the idle branch below lowers it
         case (bus_ff)
            HSCC_BUS_IDLE: begin
               if (avs_read_i || avs_write_i) begin
                  bus_ff   <= HSCC_BUS_ACK;
                  rdata_ff <= rd_mux;
                  wait_ff  <= 1'b0;
               end
            end
            HSCC_BUS_ACK: bus_ff <= HSCC_BUS_IDLE;
            default:      bus_ff <= HSCC_BUS_IDLE;
         endcase
      end
   end

   assign avs_readdata_o    = rdata_ff;
   assign avs_waitrequest_o = wait_ff;
   assign target_bits_o     = out_bits_ff;
   assign scan_contact_o    = scan_out_ff;
   assign irq_o             = irq_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_irq_evt; (evt_set & irq_mask_ff) != '0; endsequence
   sequence s_irq_seen; ##[1:2] irq_o; endsequence
   property p_idle_hold; !ctrl_ff[CTRL_EN] && !wr_count |=> $stable(count_ff); endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("count moved while disabled");
   property p_single_dir; step && !ctrl_ff[CTRL_QUAD] && !cnt_zero |=>
      count_ff == ($past(ctrl_ff[CTRL_DOWN]) ? $past(count_ff) - 32'sd1 : $past(count_ff) + 32'sd1); endproperty
   a_single_dir: assert property (p_single_dir) else $error("single-phase step wrong");
   property p_quad_flag; step && ctrl_ff[CTRL_QUAD] |=> qdir_ff == !$past(sync2_ff[1]); endproperty
   a_quad_flag: assert property (p_quad_flag) else $error("quadrature flag wrong");
   property p_start_gate; ctrl_ff[CTRL_START] && !sync2_ff[2] && !wr_count |=> $stable(count_ff); endproperty
   a_start_gate: assert property (p_start_gate) else $error("counted with start off");
   property p_ext_clear; clr_in && !wr_count |=> count_ff == 32'sd0 && !contact_ff; endproperty
   a_ext_clear: assert property (p_ext_clear) else $error("clear input ignored");
   property p_set_bits; set_mask != '0 |=> (out_bits_ff & $past(set_mask)) == $past(set_mask); endproperty
   a_set_bits: assert property (p_set_bits) else $error("compare-set bit not set");
   property p_clr_bits; (clr_mask & ~set_mask) != '0 |=>
      (out_bits_ff & $past(clr_mask & ~set_mask)) == '0; endproperty
   a_clr_bits: assert property (p_clr_bits) else $error("compare-clear bit not cleared");
   property p_irq_path; s_irq_evt |-> s_irq_seen; endproperty
   a_irq_path: assert property (p_irq_path) else $error("interrupt not raised");
   property p_load_quiet; wr_count |=> count_ff == $past(avs_writedata_i) && $stable(out_bits_ff); endproperty
   a_load_quiet: assert property (p_load_quiet) else $error("load fired a compare");
   property p_six_max; $countones(active) <= MAX_ACT; endproperty
   a_six_max: assert property (p_six_max) else $error("more than six slots active");
   property p_contact_up; step && !dir_down && nxt_count == preset_ff && !clr_in |=> contact_ff; endproperty
   a_contact_up: assert property (p_contact_up) else $error("contact not set");
   property p_scan_only; !(wr_en && avs_address_i == A_SCAN) |=> $stable(scan_contact_o); endproperty
   a_scan_only: assert property (p_scan_only) else $error("scan output moved off scan");
   property p_pos_write; (wr_pos & pos_hit) == '0; endproperty
   a_pos_write: assert property (p_pos_write) else $error("position write fired");
   property p_once; hit != '0 |=> hit == '0; endproperty
   a_once: assert property (p_once) else $error("compare re-fired");
endmodule

// ---- sim/hscc_pulse_src.sv ----
// pulse pin model: drives the count and second-phase pins
// assumes the caller enters send just after a rising clock edge
`timescale 1ns/1ps
module hscc_pulse_src (
   input  wire logic ref_clk_i,
   output logic      pulse_a_o,
   output logic      pulse_b_o
);
   initial begin
      pulse_a_o = 1'b0;
      pulse_b_o = 1'b0;
   end
   // four cycles high, four low: clears the two-stage pin sync
   task automatic send(input int n, input logic b_lvl);
      pulse_b_o <= b_lvl;
      repeat (4) @(posedge ref_clk_i);
      for (int i = 0; i < n; i++) begin
         pulse_a_o <= 1'b1;
         repeat (4) @(posedge ref_clk_i);
         pulse_a_o <= 1'b0;
         repeat (4) @(posedge ref_clk_i);
      end
      pulse_b_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the fast count/compare block
// assumes one 200 MHz clock and the one-wait-state avalon slave
`timescale 1ns/1ps
module tb;
   import hscc_pkg::*;
   logic ref_clk = 0, srst = 1, rd = 0, wr = 0, pa, pb;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wd = '0, rq, rdata;
   logic [OUT_W-1:0]  tbits;
   logic              wait_rq, scan_c, irq;
   logic [31:0]       seed = 32'h0001_79B7;
   int bad_count = 0, samples_checked = 0, n, k;
   logic               st = 1'b0, cl = 1'b0;
   logic [NUM_POS-1:0] pstep = '0, pdn = '0;
   logic [31:0]        v;
   always #2.5 ref_clk = ~ref_clk;
   hscc_top uut (.ref_clk_i(ref_clk), .srst_i(srst), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq),
      .pulse_a_i(pa), .pulse_b_i(pb), .ext_start_i(st), .ext_clear_i(cl), .pos_step_i(pstep),
      .pos_dir_down_i(pdn), .target_bits_o(tbits), .scan_contact_o(scan_c), .irq_o(irq));
   hscc_pulse_src src (.ref_clk_i(ref_clk), .pulse_a_o(pa), .pulse_b_o(pb));
   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   // expected count after m steps in one direction
   function automatic logic [31:0] cnt_exp(input logic [31:0] base, input int m, input logic dn);
      return dn ? base - m : base + m;
   endfunction
   // holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int i;
      rd <= ~w;
      wr <= w;
      addr <= a;
      wd <= d;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (wait_rq !== 1'b0 && i < 50);
      if (wait_rq !== 1'b0) begin
         $display("[ERR] waitrequest expected 0 seen %b", wait_rq);
         bad_count++;
      end
      rq = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk);
      chk("wait in reset", 1, wait_rq);
      srst <= 1'b0;
      @(posedge ref_clk);
      seed = xs(seed);
      n = 3 + int'(seed[2:0]);
      src.send(n, 1'b0);
      bus(0, A_COUNT, 0); chk("count off", 0, rq);
      bus(1, A_CTRL, 32'h0000_0001);
      src.send(n, 1'b0);
      bus(0, A_COUNT, 0); chk("count up", n, rq);
      $display("test count done");
      bus(1, A_SLOT_CFG, 32'h0000_0031);
      bus(1, A_SLOT_CFG + 1, 32'h0000_0053);
      bus(1, A_SLOT_CFG + 2, 32'h0000_0005);
      for (int s = 0; s < 3; s++) bus(1, A_SLOT_VAL + s, n + 2);
      bus(1, A_IRQ_MASK, 32'h0000_0001);
      bus(1, A_OUTBITS, 32'h0000_0020);
      bus(1, A_COUNT, n + 2);
      bus(0, A_OUTBITS, 0); chk("load no act", 32'h20, rq);
      bus(0, A_IRQ_STS, 0); chk("load no irq", 0, rq);
      bus(1, A_COUNT, n);
      src.send(2, 1'b0);
      bus(0, A_OUTBITS, 0); chk("set clr", 32'h08, rq);
      bus(0, A_IRQ_STS, 0); chk("irq sts", 1, rq);
      chk("irq out", 1, irq);
      bus(1, A_IRQ_STS, 32'h0000_0001);
      bus(0, A_IRQ_STS, 0); chk("irq w1c", 0, irq);
      chk("sts w1c", 0, rq);
      $display("test compare done");
      bus(1, A_SLOT_CFG + 3, 32'h0000_000B);
      bus(1, A_SLOT_VAL + 3, 32'h8000_0000);
      bus(1, A_COUNT, 32'h8000_0002);
      bus(1, A_CTRL, 32'h0000_0005);
      src.send(2, 1'b0);
      bus(0, A_COUNT, 0); chk("self clear", 0, rq);
      bus(1, A_CTRL, 32'h0000_0003);
      src.send(1, 1'b0);
      bus(0, A_STATE, 0); chk("quad flag", 1, rq[1]);
      bus(0, A_COUNT, 0); chk("quad up", 1, rq);
      src.send(1, 1'b1);
      bus(0, A_STATE, 0);
      chk("quad flag clr", 0, rq[1]);
      bus(0, A_COUNT, 0);
      chk("quad down", 0, rq);
      $display("test down and quad done");
      bus(1, A_CTRL, 32'h0000_0001);
      bus(1, A_PRESET, 32'h0000_0002);
      src.send(3, 1'b0);
      bus(0, A_STATE, 0);
      chk("contact up", 1, rq[0]);
      chk("scan hold", 0, scan_c);
      bus(1, A_SCAN, 0);
      chk("scan copy", 1, scan_c);
      bus(1, A_CTRL, 32'h0000_0005);
      src.send(1, 1'b0);
      bus(0, A_COUNT, 0);
      chk("count down", cnt_exp(3, 1, 1'b1), rq);
      bus(0, A_STATE, 0);
      chk("contact down", 0, rq[0]);
      chk("scan stays", 1, scan_c);
      bus(1, A_PRESET, 32'h0000_0003);
      bus(1, A_CTRL, 32'h0000_0009);
      src.send(2, 1'b0);
      bus(0, A_COUNT, 0);
      chk("start off", 2, rq);
      st <= 1'b1;
      src.send(2, 1'b0);
      bus(0, A_COUNT, 0);
      chk("start on", cnt_exp(2, 2, 1'b0), rq);
      bus(0, A_STATE, 0);
      chk("contact before clear", 1, rq[0]);
      cl <= 1'b1;
      repeat (4) @(posedge ref_clk);
      cl <= 1'b0;
      repeat (4) @(posedge ref_clk);
      bus(0, A_COUNT, 0);
      chk("ext clear", 0, rq);
      bus(0, A_STATE, 0);
      chk("clear contact", 0, rq[0]);
      seed = xs(seed);
      v = 32'd20 + seed[3:0];
      for (int s = 4; s < 8; s++) begin
         bus(1, A_SLOT_CFG + s, 32'h0000_0041 + (s << 4));
         bus(1, A_SLOT_VAL + s, v);
      end
      bus(1, A_COUNT, v - 2);
      src.send(2, 1'b0);
      bus(0, A_OUTBITS, 0);
      chk("six slots", 32'h0000_0308, rq);
      $display("test contact start and slots done");
      seed = xs(seed);
      k = seed % 6;
      bus(1, A_POS_CMP + ADDR_W'(k), seed);
      bus(1, A_POS + ADDR_W'(k), seed);
      bus(0, A_IRQ_STS, 0);
      chk("pos write quiet", 0, rq & 32'h0000_0FC0);
      bus(1, A_POS + ADDR_W'(k), cnt_exp(seed, 2, 1'b0));
      pdn[k] <= 1'b1;
      repeat (2) begin
         pstep[k] <= 1'b1;
         @(posedge ref_clk);
         pstep[k] <= 1'b0;
         @(posedge ref_clk);
      end
      bus(0, A_IRQ_STS, 0);
      chk("pos irq", 32'h0000_0040 << k, rq & 32'h0000_0FC0);
      bus(0, A_POS + ADDR_W'(k), 0);
      chk("pos value", seed, rq);
      $display("test position done");
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      finish_test();
   end
endmodule
